// ### hdl/pcub_regs.vh
`ifndef PCUB_REGS_VH
`define PCUB_REGS_VH
// Register byte addresses, one 32-bit word (four bytes) apart.
`define PCUB_ADDR_CTRL 8'h00
`define PCUB_ADDR_PCT 8'h04
`define PCUB_ADDR_DELAY 8'h08
`define PCUB_ADDR_RATED 8'h0c
`define PCUB_ADDR_STATUS 8'h10
`define PCUB_ADDR_IRQ_STAT 8'h14
`define PCUB_ADDR_IRQ_EN 8'h18
`define PCUB_ADDR_IRQ_CLR 8'h1c
`define PCUB_ADDR_MAGS 8'h20
// Control field positions.
`define PCUB_CTRL_OPER 0
`define PCUB_CTRL_STONLY 1
// Status and interrupt field positions.
`define PCUB_ST_START 0
`define PCUB_ST_TRIP 1
`define PCUB_ST_UNBAL 2
`define PCUB_ST_SUFF 3
`define PCUB_ST_NOFLT 4
// Reset values and ranges.
`define PCUB_PCT_DEF 7'h32
`define PCUB_PCT_MIN 7'h0a
`define PCUB_PCT_MAX 7'h5a
`define PCUB_DLY_DEF 16'h03e8
`define PCUB_DLY_MIN 16'h0064
`define PCUB_DLY_MAX 16'hea60
`define PCUB_RATED_DEF 16'h0400
// Ten percent and one hundred fifty percent of rated current.
`define PCUB_SUFF_PCT 8'h0a
`define PCUB_FLT_PCT 8'h96
// Clock figures: 10 MHz, one millisecond tick.
`define PCUB_CLK_KHZ 10000
`define PCUB_TICK_MS 1
`endif

// ### hdl/pcub_ms_tick.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Millisecond enable divider
module pcub_ms_tick #(
    parameter CYCLES = 10000
) (
    input wire ref_clk,
    input wire rst_n,
    output reg msTick
);
    reg [15:0] cnt_r;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 16'h0000;
            msTick <= 1'b0;
        end
        else if (cnt_r == CYCLES[15:0] - 16'h0001)
        begin
            cnt_r <= 16'h0000;
            msTick <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 16'h0001;
            msTick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### hdl/pcub_detector.v
`timescale 1ns/1ps
`default_nettype none
`include "pcub_regs.vh"
module pcub_detector #(
    parameter MAG_W = 16,
    // Clock cycles per millisecond tick; a smaller value only shortens simulation runs.
    parameter TICK_CYCLES = `PCUB_CLK_KHZ * `PCUB_TICK_MS
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [MAG_W-1:0] phase1RmsMag,
    input wire [MAG_W-1:0] phase2RmsMag,
    input wire [MAG_W-1:0] phase3RmsMag,
    input wire userBlockInput,
    input wire [7:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdata,
    output wire generalStartOut,
    output wire generalTripOut,
    output wire maxCurrentSufficientFlag,
    output wire maxCurrentNotFaultFlag,
    output wire irqOut
);
    // ==========================================
    // Input synchronisers for the asynchronous blocking pin
    reg blkMeta_r;
    reg blkSync_r;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blkMeta_r <= 1'b0;
            blkSync_r <= 1'b0;
        end
        else
        begin
            blkMeta_r <= userBlockInput;
            blkSync_r <= blkMeta_r;
        end
    end

    // ==========================================
    // Settings registers
    reg oper_r;
    reg startOnly_r;
    reg [6:0] pct_r;
    reg [15:0] delay_r;
    reg [MAG_W-1:0] rated_r;
    reg [4:0] irqStat_r;
    reg [4:0] irqEn_r;
    wire [4:0] status;
    reg [4:0] statusPrev_r;
    wire [4:0] rise = status & ~statusPrev_r;

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oper_r <= 1'b0;
            startOnly_r <= 1'b0;
            pct_r <= `PCUB_PCT_DEF;
            delay_r <= `PCUB_DLY_DEF;
            rated_r <= `PCUB_RATED_DEF;
            irqEn_r <= 5'h00;
        end
        else if (regWr)
        begin
            case (regAddr)
                `PCUB_ADDR_CTRL:
                begin
                    oper_r <= regWdata[`PCUB_CTRL_OPER];
                    startOnly_r <= regWdata[`PCUB_CTRL_STONLY];
                end
                `PCUB_ADDR_PCT:
                begin
                    // Out-of-range values are clamped to the nearest legal setting.
                    if (regWdata[6:0] < `PCUB_PCT_MIN || regWdata[31:7] != 25'h0)
                        pct_r <= (regWdata[31:7] != 25'h0) ? `PCUB_PCT_MAX : `PCUB_PCT_MIN;
                    else if (regWdata[6:0] > `PCUB_PCT_MAX)
                        pct_r <= `PCUB_PCT_MAX;
                    else
                        pct_r <= regWdata[6:0];
                end
                `PCUB_ADDR_DELAY:
                begin
                    if (regWdata[15:0] < `PCUB_DLY_MIN || regWdata[31:16] != 16'h0)
                        delay_r <= (regWdata[31:16] != 16'h0) ? `PCUB_DLY_MAX : `PCUB_DLY_MIN;
                    else if (regWdata[15:0] > `PCUB_DLY_MAX)
                        delay_r <= `PCUB_DLY_MAX;
                    else
                        delay_r <= regWdata[15:0];
                end
                `PCUB_ADDR_RATED: rated_r <= regWdata[MAG_W-1:0];
                `PCUB_ADDR_IRQ_EN: irqEn_r <= regWdata[4:0];
                default: ;
            endcase
        end
    end

    // Sticky events; a new event in the clear cycle wins over the clear.
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irqStat_r <= 5'h00;
            statusPrev_r <= 5'h00;
        end
        else
        begin
            statusPrev_r <= status;
            if (regWr && regAddr == `PCUB_ADDR_IRQ_CLR)
                irqStat_r <= (irqStat_r & ~regWdata[4:0]) | rise;
            else
                irqStat_r <= irqStat_r | rise;
        end
    end
    assign irqOut = |(irqStat_r & irqEn_r);

    // ==========================================
    // Analogue signal processing, registered in two stages
    reg [MAG_W-1:0] max_r;
    reg [MAG_W-1:0] min_r;
    wire [MAG_W-1:0] max12 = (phase1RmsMag > phase2RmsMag) ? phase1RmsMag : phase2RmsMag;
    wire [MAG_W-1:0] min12 = (phase1RmsMag < phase2RmsMag) ? phase1RmsMag : phase2RmsMag;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            max_r <= {MAG_W{1'b0}};
            min_r <= {MAG_W{1'b0}};
        end
        else
        begin
            max_r <= (max12 > phase3RmsMag) ? max12 : phase3RmsMag;
            min_r <= (min12 < phase3RmsMag) ? min12 : phase3RmsMag;
        end
    end

    // Percent comparisons are cross-multiplied so no divider is needed.
    wire [MAG_W+7:0] diffScaled = {8'h00, max_r - min_r} * 8'd100;
    wire [MAG_W+7:0] limScaled = {8'h00, max_r} * {1'b0, pct_r};
    wire [MAG_W+7:0] maxScaled = {8'h00, max_r} * 8'd100;
    wire [MAG_W+7:0] suffScaled = {8'h00, rated_r} * `PCUB_SUFF_PCT;
    wire [MAG_W+7:0] fltScaled = {8'h00, rated_r} * `PCUB_FLT_PCT;
    reg unbal_r;
    reg suff_r;
    reg noFlt_r;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            unbal_r <= 1'b0;
            suff_r <= 1'b0;
            noFlt_r <= 1'b0;
        end
        else
        begin
            unbal_r <= diffScaled > limScaled;
            suff_r <= maxScaled > suffScaled;
            noFlt_r <= maxScaled < fltScaled;
        end
    end

    // ==========================================
    // Decision logic
    wire enabled = oper_r && !blkSync_r;
    wire startCond = enabled && unbal_r && suff_r && noFlt_r;
    wire msTick;
    pcub_ms_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .msTick(msTick)
    );

    reg start_r;
    reg trip_r;
    reg [15:0] elapsed_r;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start_r <= 1'b0;
            trip_r <= 1'b0;
            elapsed_r <= 16'h0000;
        end
        else if (!startCond)
        begin
            start_r <= 1'b0;
            trip_r <= 1'b0;
            elapsed_r <= 16'h0000;
        end
        else
        begin
            start_r <= 1'b1;
            if (msTick && elapsed_r < delay_r)
                elapsed_r <= elapsed_r + 16'h0001;
            trip_r <= (elapsed_r >= delay_r) && !startOnly_r;
        end
    end

    assign generalStartOut = start_r;
    assign generalTripOut = trip_r;
    assign maxCurrentSufficientFlag = suff_r && enabled;
    assign maxCurrentNotFaultFlag = noFlt_r && enabled;
    assign status = {maxCurrentNotFaultFlag, maxCurrentSufficientFlag, unbal_r && enabled,
                     trip_r, start_r};

    // ==========================================
    // Register read port, data valid the cycle after the strobe
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            regRdata <= 32'h00000000;
        else if (regRd)
        begin
            case (regAddr)
                `PCUB_ADDR_CTRL: regRdata <= {30'h0, startOnly_r, oper_r};
                `PCUB_ADDR_PCT: regRdata <= {25'h0, pct_r};
                `PCUB_ADDR_DELAY: regRdata <= {16'h0, delay_r};
                `PCUB_ADDR_RATED: regRdata <= {{(32-MAG_W){1'b0}}, rated_r};
                `PCUB_ADDR_STATUS: regRdata <= {27'h0, status};
                `PCUB_ADDR_IRQ_STAT: regRdata <= {27'h0, irqStat_r};
                `PCUB_ADDR_IRQ_EN: regRdata <= {27'h0, irqEn_r};
                `PCUB_ADDR_MAGS: regRdata <= {max_r, min_r};
                default: regRdata <= 32'h00000000;
            endcase
        end
        else
            regRdata <= 32'h00000000;
    end
endmodule
`default_nettype wire

// ### sim/pcub_mag_src.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Upstream magnitude stage
// Each new set of magnitudes reaches the detector one edge after it is requested.
module pcub_mag_src (
    input wire ref_clk,
    input wire rst_n,
    input wire logic [15:0] setA,
    input wire logic [15:0] setB,
    input wire logic [15:0] setC,
    output logic [15:0] phase1RmsMag,
    output logic [15:0] phase2RmsMag,
    output logic [15:0] phase3RmsMag
);
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase1RmsMag <= 16'h0000;
            phase2RmsMag <= 16'h0000;
            phase3RmsMag <= 16'h0000;
        end
        else
        begin
            phase1RmsMag <= setA;
            phase2RmsMag <= setB;
            phase3RmsMag <= setC;
        end
    end
endmodule
`default_nettype wire

// ### sim/pcub_detector_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checks
module pcub_detector_chk #(
    parameter MAG_W = 16
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [MAG_W-1:0] phase1RmsMag,
    input wire [MAG_W-1:0] phase2RmsMag,
    input wire [MAG_W-1:0] phase3RmsMag,
    input wire userBlockInput,
    input wire [7:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    input wire [31:0] regRdata,
    input wire generalStartOut,
    input wire generalTripOut,
    input wire maxCurrentSufficientFlag,
    input wire maxCurrentNotFaultFlag,
    input wire irqOut
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire eqMags = phase1RmsMag == phase2RmsMag && phase2RmsMag == phase3RmsMag;
    wire zeroMags = ~|{phase1RmsMag, phase2RmsMag, phase3RmsMag};
    rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data not zero outside a read");
    trip_needs_start_a: assert property (generalTripOut |-> generalStartOut)
        else $error("trip without start");
    block_quiet_a: assert property (userBlockInput [*4] |=> !generalStartOut)
        else $error("start while blocked");
    start_flags_a: assert property ($rose(generalStartOut) |->
        $past(maxCurrentSufficientFlag && maxCurrentNotFaultFlag))
        else $error("start without valid current band");
    trip_delay_a: assert property ($rose(generalTripOut) |-> $past(generalStartOut, 8))
        else $error("trip too soon after start");
    lapse_clear_a: assert property ($fell(generalStartOut) |-> !generalTripOut [*2])
        else $error("trip held after start lapsed");
    zero_insuff_a: assert property (zeroMags [*3] |=> !maxCurrentSufficientFlag)
        else $error("sufficiency with zero current");
    equal_nostart_a: assert property (eqMags [*4] |=> !generalStartOut)
        else $error("start with balanced phases");
    cover property ($rose(generalStartOut));
    cover property ($fell(generalStartOut));
    cover property ($rose(generalTripOut));
    cover property ($rose(irqOut));
endmodule
bind pcub_detector pcub_detector_chk #(.MAG_W(MAG_W)) u_pcub_detector_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .phase1RmsMag(phase1RmsMag),
    .phase2RmsMag(phase2RmsMag), .phase3RmsMag(phase3RmsMag),
    .userBlockInput(userBlockInput), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .generalStartOut(generalStartOut),
    .generalTripOut(generalTripOut), .maxCurrentSufficientFlag(maxCurrentSufficientFlag),
    .maxCurrentNotFaultFlag(maxCurrentNotFaultFlag), .irqOut(irqOut));
`default_nettype wire

// ### sim/pcub_detector_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcub_regs.vh"
// ==========================================
// Testbench
module pcub_detector_tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic userBlockInput = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic rdSeen = 1'b0;
    logic [15:0] setM [3] = '{default: 16'h0};
    wire [15:0] m1, m2, m3;
    wire [31:0] regRdata;
    wire startO, tripO, suffO, nofltO, irqO;
    logic [31:0] expQ [$];
    int err_total = 0;
    int compares = 0;
    pcub_mag_src u_pcub_mag_src (.ref_clk(ref_clk), .rst_n(rst_n), .setA(setM[0]),
        .setB(setM[1]), .setC(setM[2]), .phase1RmsMag(m1), .phase2RmsMag(m2), .phase3RmsMag(m3));
    // A ten-cycle millisecond keeps the trip delay inside a short run.
    pcub_detector #(.TICK_CYCLES(10)) u_pcub_detector (.ref_clk(ref_clk), .rst_n(rst_n),
        .phase1RmsMag(m1),
        .phase2RmsMag(m2), .phase3RmsMag(m3), .userBlockInput(userBlockInput),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .generalStartOut(startO), .generalTripOut(tripO),
        .maxCurrentSufficientFlag(suffO), .maxCurrentNotFaultFlag(nofltO), .irqOut(irqO));
    initial forever #50 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    // The expected word is queued first; the monitor below compares it a cycle later.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
    endtask
    // A random rotation puts the largest value on any of the three phases.
    task automatic setm(input logic [15:0] hi, lo, mid, input logic [31:0] st);
        int r;
        r = $urandom % 3;
        @(posedge ref_clk);
        setM[r] <= hi;
        setM[(r + 1) % 3] <= lo;
        setM[(r + 2) % 3] <= mid;
        repeat (6) @(posedge ref_clk);
        rd(`PCUB_ADDR_STATUS, st);
    endtask
    always @(posedge ref_clk) rdSeen <= regRd;
    always @(negedge ref_clk)
    begin
        if (rdSeen)
            chk(regRdata, expQ.pop_front());
    end
    initial
    begin
        #(20000 * 100);
        err_total++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(32'hde2af03a));
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`PCUB_ADDR_CTRL, 32'h0);
        rd(`PCUB_ADDR_PCT, 32'h32);
        rd(`PCUB_ADDR_DELAY, 32'h3e8);
        rd(`PCUB_ADDR_RATED, 32'h400);
        rd(`PCUB_ADDR_STATUS, 32'h0);
        rd(8'h40, 32'h0);
        wr(`PCUB_ADDR_PCT, 32'h5);
        rd(`PCUB_ADDR_PCT, 32'ha);
        wr(`PCUB_ADDR_PCT, 32'h64);
        rd(`PCUB_ADDR_PCT, 32'h5a);
        wr(`PCUB_ADDR_DELAY, 32'h1);
        rd(`PCUB_ADDR_DELAY, 32'h64);
        wr(`PCUB_ADDR_DELAY, 32'hffff);
        rd(`PCUB_ADDR_DELAY, 32'hea60);
        wr(`PCUB_ADDR_DELAY, 32'h64);
        wr(`PCUB_ADDR_PCT, 32'h32);
        wr(`PCUB_ADDR_IRQ_EN, 32'h1);
        wr(`PCUB_ADDR_CTRL, 32'h1);
        setm(16'h400, 16'h400, 16'h400, 32'h18);
        setm(16'h400, 16'h100, 16'h200, 32'h1d);
        chk(32'(irqO), 32'h1);
        rd(`PCUB_ADDR_IRQ_STAT, 32'h1d);
        wr(`PCUB_ADDR_IRQ_CLR, 32'h1f);
        rd(`PCUB_ADDR_IRQ_STAT, 32'h0);
        chk(32'(irqO), 32'h0);
        wr(`PCUB_ADDR_IRQ_EN, 32'h0);
        setm(16'h400, 16'h200, 16'h200, 32'h18);
        setm(16'h400, 16'h1ff, 16'h300, 32'h1d);
        chk(32'(irqO), 32'h0);
        rd(`PCUB_ADDR_IRQ_STAT, 32'h5);
        wr(`PCUB_ADDR_IRQ_EN, 32'h1);
        // The enable lands on the write's own edge, so the line is looked at one edge later.
        @(posedge ref_clk);
        chk(32'(irqO), 32'h1);
        setm(16'h600, 16'h0, 16'h100, 32'hc);
        setm(16'h66, 16'h0, 16'h10, 32'h14);
        setm(16'h67, 16'h0, 16'h10, 32'h1d);
        rd(`PCUB_ADDR_MAGS, 32'h00670000);
        userBlockInput <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk(32'({startO, suffO, nofltO, tripO}), 32'h0);
        userBlockInput <= 1'b0;
        // One hundred ticks of ten cycles: still waiting at 900 cycles, tripped by 1100.
        repeat (900) @(posedge ref_clk);
        chk(32'({startO, tripO}), 32'h2);
        repeat (200) @(posedge ref_clk);
        chk(32'({startO, tripO}), 32'h3);
        wr(`PCUB_ADDR_CTRL, 32'h3);
        repeat (6) @(posedge ref_clk);
        chk(32'({startO, tripO}), 32'h2);
        wr(`PCUB_ADDR_CTRL, 32'h0);
        repeat (6) @(posedge ref_clk);
        chk(32'({startO, suffO, nofltO}), 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
